// ===== verilog/fsp_pkg.sv
// Shared constants and types of the flow controlled serial port.
package fsp_pkg;

    // ==========================================================
    // Clock and line rate
    localparam int CLK_HZ = 125_000_000;
    localparam int BIT_RATE_MAX = 2_000_000;

    // ==========================================================
    // Frame shape
    localparam int DATA_BITS = 8;
    localparam int STOP_BITS = 1;
    localparam int START_BITS = 1;
    localparam int FRAME_BITS = START_BITS + DATA_BITS + STOP_BITS;

    // ==========================================================
    // Line levels
    localparam logic LINE_IDLE = 1'b1;
    localparam logic START_LEVEL = 1'b0;
    localparam logic HS_ON = 1'b0;
    localparam logic HS_OFF = 1'b1;
    localparam logic PULLUP_ON = 1'b1;

    // ==========================================================
    // Receive buffer and bit timer width
    localparam int BUF_DEPTH = 1024;
    localparam int RTS_MARGIN = 16;
    localparam int CYC_W = 16;

    // ==========================================================
    // Carriers
    typedef logic [DATA_BITS-1:0] fsp_byte_t;

    typedef struct packed {
        fsp_byte_t data;
        logic frame_err;
    } fsp_char_t;

endpackage : fsp_pkg

// ===== verilog/fsp_tx.sv
// Transmit serialiser of the flow controlled serial port.
`timescale 1ns/100ps
module fsp_tx #(
    parameter int BIT_CYC = 62
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic go_ok,
    input wire fsp_pkg::fsp_byte_t tx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    output logic busy,
    output logic line
);
    import fsp_pkg::*;

    typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP}
        fsp_tx_state_t;

    localparam logic [CYC_W-1:0] LAST_CYC = CYC_W'(BIT_CYC - 1);
    localparam logic [2:0] LAST_BIT = 3'(DATA_BITS - 1);

    fsp_tx_state_t state_reg;
    logic [CYC_W-1:0] cyc_reg;
    logic [2:0] bit_reg;
    fsp_byte_t shift_reg;
    logic line_reg;
    logic bit_end;

    assign bit_end = cyc_reg == LAST_CYC;
    assign tx_ready = (state_reg == TX_IDLE) && go_ok;
    assign busy = state_reg != TX_IDLE;
    assign line = line_reg;

    // ==========================================================
    // Bit timer
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cyc_reg <= '0;
        end else if (state_reg == TX_IDLE || bit_end) begin
            cyc_reg <= '0;
        end else begin
            cyc_reg <= cyc_reg + 1'b1;
        end
    end

    // ==========================================================
    // Frame sequencer
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= TX_IDLE;
            shift_reg <= '0;
            bit_reg <= '0;
            line_reg <= LINE_IDLE;
        end else begin
            unique case (state_reg)
                TX_IDLE: begin
                    if (tx_valid && tx_ready) begin
                        state_reg <= TX_START;
                        shift_reg <= tx_data;
                        line_reg <= START_LEVEL;
                    end
                end
                TX_START: begin
                    if (bit_end) begin
                        state_reg <= TX_DATA;
                        bit_reg <= '0;
                        line_reg <= shift_reg[0];
                        shift_reg <= shift_reg >> 1;
                    end
                end
                TX_DATA: begin
                    if (bit_end && bit_reg == LAST_BIT) begin
                        state_reg <= TX_STOP;
                        line_reg <= LINE_IDLE;
                    end else if (bit_end) begin
                        bit_reg <= bit_reg + 1'b1;
                        line_reg <= shift_reg[0];
                        shift_reg <= shift_reg >> 1;
                    end
                end
                TX_STOP: begin
                    if (bit_end) begin
                        state_reg <= TX_IDLE;
                    end
                end
            endcase
        end
    end

endmodule : fsp_tx

// ===== verilog/fsp_rx.sv
// Receive deserialiser of the flow controlled serial port.
`timescale 1ns/100ps
module fsp_rx #(
    parameter int BIT_CYC = 62
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic line,
    output fsp_pkg::fsp_char_t ch,
    output logic ch_valid
);
    import fsp_pkg::*;

    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP}
        fsp_rx_state_t;

    localparam logic [CYC_W-1:0] LAST_CYC = CYC_W'(BIT_CYC - 1);
    localparam logic [CYC_W-1:0] HALF_CYC = CYC_W'(BIT_CYC / 2);
    localparam logic [2:0] LAST_BIT = 3'(DATA_BITS - 1);

    fsp_rx_state_t state_reg;
    logic [CYC_W-1:0] cyc_reg;
    logic [2:0] bit_reg;
    fsp_byte_t shift_reg;
    fsp_char_t ch_reg;
    logic valid_reg;
    logic bit_end;

    assign bit_end = cyc_reg == LAST_CYC;
    assign ch = ch_reg;
    assign ch_valid = valid_reg;

    // ==========================================================
    // Sampling happens mid-bit: the start bit is checked at its
    // centre and the timer restarts there, so every later bit end
    // falls on a bit centre.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= RX_IDLE;
            cyc_reg <= '0;
            bit_reg <= '0;
            shift_reg <= '0;
            ch_reg <= '0;
            valid_reg <= 1'b0;
        end else begin
            valid_reg <= 1'b0;
            cyc_reg <= cyc_reg + 1'b1;
            unique case (state_reg)
                RX_IDLE: begin
                    cyc_reg <= '0;
                    if (line == START_LEVEL) begin
                        state_reg <= RX_START;
                    end
                end
                RX_START: begin
                    if (cyc_reg == HALF_CYC) begin
                        cyc_reg <= '0;
                        bit_reg <= '0;
                        state_reg <= (line == START_LEVEL) ? RX_DATA
                                                           : RX_IDLE;
                    end
                end
                RX_DATA: begin
                    if (bit_end) begin
                        cyc_reg <= '0;
                        shift_reg <= {line, shift_reg[DATA_BITS-1:1]};
                        bit_reg <= bit_reg + 1'b1;
                        if (bit_reg == LAST_BIT) begin
                            state_reg <= RX_STOP;
                        end
                    end
                end
                RX_STOP: begin
                    if (bit_end) begin
                        // No parity: the stop level is the only check.
                        ch_reg.data <= shift_reg;
                        ch_reg.frame_err <= line != LINE_IDLE;
                        valid_reg <= 1'b1;
                        state_reg <= RX_IDLE;
                    end
                end
            endcase
        end
    end

endmodule : fsp_rx

// ===== verilog/fsp_port.sv
// Top level of the flow controlled serial port.
`timescale 1ns/100ps

module fsp_port #(
    parameter int BIT_RATE = fsp_pkg::BIT_RATE_MAX,
    parameter int DEPTH = fsp_pkg::BUF_DEPTH,
    parameter int MARGIN = fsp_pkg::RTS_MARGIN
) (
    input wire logic clk,
    input wire logic arst_n,
    // Port enable from firmware; RTS and the transmit pin only go active once set, the receive pin is always sampled.
    input wire logic port_open,
    // Receive data pin.
    input wire logic gp_pin_zero,
    // Transmit data pin.
    output logic gp_pin_one,
    // Request-to-send pin, active low.
    output logic gp_pin_two_n,
    // Clear-to-send pin, active low.
    input wire logic gp_pin_three_n,
    output logic rx_pullup_en,
    output logic cts_pullup_en,
    input wire fsp_pkg::fsp_byte_t tx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    output logic tx_busy,
    output fsp_pkg::fsp_char_t rx_char,
    output logic rx_valid,
    input wire logic rx_ready,
    output logic rx_overrun,
    output logic [$clog2(fsp_pkg::BUF_DEPTH+1)-1:0] rx_level
);
    import fsp_pkg::*;

    // ==========================================================
    // Derived timing and elaboration checks
    localparam int BIT_CYC = CLK_HZ / BIT_RATE;
    localparam int PTR_W = $clog2(DEPTH);
    localparam int LVL_W = $clog2(BUF_DEPTH + 1);
    localparam logic [LVL_W-1:0] FULL_LVL = LVL_W'(DEPTH);
    localparam logic [LVL_W-1:0] STOP_LVL = LVL_W'(DEPTH - MARGIN);
    localparam logic [CYC_W-1:0] FRAME_CYC = CYC_W'(FRAME_BITS * BIT_CYC);

    if (BIT_RATE > BIT_RATE_MAX || BIT_RATE <= 0) begin : g_bad_rate
        $error("Bit rate outside the supported range.");
    end
    if (BIT_CYC < 4 || FRAME_BITS * BIT_CYC >= 2 ** CYC_W)
    begin : g_bad_cyc
        $error("Bit time does not fit the bit timers.");
    end
    // Smaller power-of-two depths keep the same logic and let a short
    // run reach the full and overrun corners.
    if (DEPTH > BUF_DEPTH || DEPTH < 2 || (1 << PTR_W) != DEPTH)
    begin : g_bad_depth
        $error("Receive buffer depth must be a power of two up to 1024.");
    end
    if (MARGIN < 2 || MARGIN >= DEPTH) begin : g_bad_margin
        $error("Flow control margin out of range.");
    end

    // ==========================================================
    // Pin synchronisers
    // Both idle levels are high, so the chains reset high and a
    // floating pin held up by its pull-up reads as idle.
    logic rxd_meta_reg;
    logic rxd_sync_reg;
    logic cts_meta_reg;
    logic cts_sync_reg;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rxd_meta_reg <= LINE_IDLE;
            rxd_sync_reg <= LINE_IDLE;
        end else begin
            rxd_meta_reg <= gp_pin_zero;
            rxd_sync_reg <= rxd_meta_reg;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cts_meta_reg <= HS_OFF;
            cts_sync_reg <= HS_OFF;
        end else begin
            cts_meta_reg <= gp_pin_three_n;
            cts_sync_reg <= cts_meta_reg;
        end
    end

    assign rx_pullup_en = PULLUP_ON;
    assign cts_pullup_en = PULLUP_ON;

    // ==========================================================
    // Transmit path
    // CTS is only looked at before a frame starts; a frame already
    // on the wire always completes so the host never sees a torn
    // character.
    logic tx_go_ok;

    assign tx_go_ok = port_open && (cts_sync_reg == HS_ON);

    fsp_tx #(
        .BIT_CYC(BIT_CYC)
    ) u_tx (
        .clk(clk),
        .arst_n(arst_n),
        .go_ok(tx_go_ok),
        .tx_data(tx_data),
        .tx_valid(tx_valid),
        .tx_ready(tx_ready),
        .busy(tx_busy),
        .line(gp_pin_one)
    );

    // ==========================================================
    // Receive path
    // Everything that arrives while the buffer has room is stored unfiltered, so application
    // data and script downloads share the same path.
    fsp_char_t rx_new;
    logic rx_new_valid;

    fsp_rx #(
        .BIT_CYC(BIT_CYC)
    ) u_rx (
        .clk(clk),
        .arst_n(arst_n),
        .line(rxd_sync_reg),
        .ch(rx_new),
        .ch_valid(rx_new_valid)
    );

    // ==========================================================
    // Receive buffer
    fsp_char_t mem [DEPTH];
    logic [PTR_W:0] wr_ptr_reg;
    logic [PTR_W:0] rd_ptr_reg;
    logic [LVL_W-1:0] level;
    logic [PTR_W:0] held_cnt;
    logic buf_full;
    logic buf_empty;
    logic do_write;
    logic do_read;
    fsp_char_t out_reg;
    logic out_valid_reg;
    logic overrun_reg;

    // The difference is taken at pointer width so that pointer wrap
    // cancels before the count is widened to the level port.
    assign held_cnt = wr_ptr_reg - rd_ptr_reg;
    assign level = LVL_W'(held_cnt);
    assign buf_full = level == FULL_LVL;
    assign buf_empty = wr_ptr_reg == rd_ptr_reg;
    assign do_write = rx_new_valid && !buf_full;
    assign do_read = !buf_empty && (!out_valid_reg || rx_ready);

    always_ff @(posedge clk) begin
        if (do_write) begin
            mem[wr_ptr_reg[PTR_W-1:0]] <= rx_new;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_ptr_reg <= '0;
        end else if (do_write) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_ptr_reg <= '0;
        end else if (do_read) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
        end
    end

    // The output stage is one more character beyond the DEPTH held in
    // the array, which keeps the read data on flip-flops.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            out_reg <= '0;
            out_valid_reg <= 1'b0;
        end else if (do_read) begin
            out_reg <= mem[rd_ptr_reg[PTR_W-1:0]];
            out_valid_reg <= 1'b1;
        end else if (rx_ready) begin
            out_valid_reg <= 1'b0;
        end
    end

    // A character arriving into a full buffer is dropped and flagged;
    // this only happens when the host ignores RTS.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            overrun_reg <= 1'b0;
        end else begin
            overrun_reg <= rx_new_valid && buf_full;
        end
    end

    assign rx_char = out_reg;
    assign rx_valid = out_valid_reg;
    assign rx_overrun = overrun_reg;
    assign rx_level = level;

    // ==========================================================
    // Request-to-send
    // RTS drops while MARGIN entries are still free, leaving room for
    // characters the host already has in its own transmitter.
    logic rts_n_reg;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rts_n_reg <= HS_OFF;
        end else if (port_open && level < STOP_LVL) begin
            rts_n_reg <= HS_ON;
        end else begin
            rts_n_reg <= HS_OFF;
        end
    end

    assign gp_pin_two_n = rts_n_reg;

    // ==========================================================
    // Checks
    logic [CYC_W-1:0] busy_cnt_reg;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            busy_cnt_reg <= '0;
        end else if (tx_busy) begin
            busy_cnt_reg <= busy_cnt_reg + 1'b1;
        end else begin
            busy_cnt_reg <= '0;
        end
    end

    a_tx_idle_high:
    assert property (@(posedge clk) disable iff (!arst_n)
        !tx_busy |-> gp_pin_one == LINE_IDLE)
    else $error("Transmit line not high while idle.");

    a_tx_frame_len:
    assert property (@(posedge clk) disable iff (!arst_n)
        $fell(tx_busy) |-> $past(busy_cnt_reg) == FRAME_CYC - 1'b1)
    else $error("Transmit frame length wrong.");

    a_tx_cts_gate:
    assert property (@(posedge clk) disable iff (!arst_n)
        $rose(tx_busy) |-> $past(cts_sync_reg) == HS_ON
                           && $past(port_open))
    else $error("Frame started without clear-to-send.");

    a_tx_start_bit:
    assert property (@(posedge clk) disable iff (!arst_n)
        $rose(tx_busy) |-> (gp_pin_one == START_LEVEL) [*8])
    else $error("Start bit not held low.");

    a_rts_closed:
    assert property (@(posedge clk) disable iff (!arst_n)
        !port_open |=> gp_pin_two_n == HS_OFF)
    else $error("RTS asserted while port closed.");

    // The reset term leaves out the release edge, where the register
    // is still held in reset although the inputs already allow RTS.
    a_rts_ready:
    assert property (@(posedge clk) disable iff (!arst_n)
        arst_n && port_open && level < STOP_LVL |=> gp_pin_two_n == HS_ON)
    else $error("RTS not asserted with room free.");

    a_rx_out_hold:
    assert property (@(posedge clk) disable iff (!arst_n)
        rx_valid && !rx_ready |=> rx_valid && $stable(rx_char))
    else $error("Received character changed before it was taken.");

    a_rts_margin:
    assert property (@(posedge clk) disable iff (!arst_n)
        level >= STOP_LVL |=> gp_pin_two_n == HS_OFF)
    else $error("RTS asserted inside the margin.");

    a_buf_overrun:
    assert property (@(posedge clk) disable iff (!arst_n)
        rx_new_valid && buf_full |=> rx_overrun
                                   && $stable(wr_ptr_reg))
    else $error("Full buffer accepted a character.");

    a_buf_store:
    assert property (@(posedge clk) disable iff (!arst_n)
        rx_new_valid && !buf_full |=>
            wr_ptr_reg == $past(wr_ptr_reg) + 1'b1)
    else $error("Received character not stored.");

    a_pullups_on:
    assert property (@(posedge clk) disable iff (!arst_n)
        rx_pullup_en && cts_pullup_en)
    else $error("Input pull-ups disabled.");

endmodule : fsp_port

// ===== tb/fsp_host_model.sv
// Host side model of the serial link: sends frames and decodes replies.
`timescale 1ns/100ps
module fsp_host_model #(
    parameter int BIT_CYC = 62
) (
    input wire logic clk,
    output logic host_txd,
    input wire logic host_rxd,
    input wire logic rts_n,
    output logic cts_n,
    input wire logic cts_hold,
    input wire logic ignore_rts,
    input wire logic bad_stop
);
    import fsp_pkg::*;
    fsp_byte_t rx_q[$];
    int stop_errs = 0;
    initial host_txd = LINE_IDLE;
    assign cts_n = cts_hold ? HS_OFF : HS_ON;
    // ==========================================================
    // Sending
    task automatic send_byte(input fsp_byte_t b);
        int n;
        n = 0;
        // Waiting out a raised request keeps the device buffer safe.
        while (!ignore_rts && rts_n !== HS_ON && n < 50000) begin
            @(posedge clk);
            n++;
        end
        @(posedge clk) host_txd <= START_LEVEL;
        repeat (BIT_CYC - 1) @(posedge clk);
        for (int i = 0; i < DATA_BITS; i++) begin
            @(posedge clk) host_txd <= b[i];
            repeat (BIT_CYC - 1) @(posedge clk);
        end
        // A bad stop bit is cut short so it cannot pass for a start bit.
        @(posedge clk) host_txd <= bad_stop ? START_LEVEL : LINE_IDLE;
        repeat ((bad_stop ? BIT_CYC / 2 + 8 : BIT_CYC) - 1) @(posedge clk);
        @(posedge clk) host_txd <= LINE_IDLE;
    endtask : send_byte
    // ==========================================================
    // Receiving
    initial begin
        forever begin
            @(posedge clk);
            if (host_rxd === START_LEVEL) begin
                fsp_byte_t b;
                logic ok;
                repeat (BIT_CYC / 2) @(posedge clk);
                ok = (host_rxd === START_LEVEL);
                for (int i = 0; i < DATA_BITS; i++) begin
                    repeat (BIT_CYC) @(posedge clk);
                    b[i] = host_rxd;
                end
                repeat (BIT_CYC) @(posedge clk);
                if (host_rxd !== LINE_IDLE || !ok) stop_errs++;
                if (ok) rx_q.push_back(b);
            end
        end
    end
endmodule : fsp_host_model

// ===== tb/test_fsp_port.sv
// Self-checking testbench of the flow controlled serial port.
`timescale 1ns/100ps
module test_fsp_port;
    import fsp_pkg::*;
    localparam int BIT_CYC = CLK_HZ / BIT_RATE_MAX;
    localparam int DEPTH = 32;
    localparam int MARGIN = 4;
    typedef struct packed {
        fsp_byte_t tx_in;
        fsp_byte_t rx_in;
        fsp_byte_t host_exp;
        fsp_char_t char_exp;
    } fsp_row_t;
    // ==========================================================
    // Signals
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic port_open = 1'b0;
    logic host_txd, dev_txd, rts_n, cts_n, rx_pullup_en, cts_pullup_en;
    fsp_byte_t tx_data = 8'h00;
    logic tx_valid = 1'b0;
    logic rx_ready = 1'b0;
    logic cts_hold = 1'b0;
    logic ignore_rts = 1'b0;
    logic bad_stop = 1'b0;
    logic tx_ready, tx_busy, rx_valid, rx_overrun;
    fsp_char_t rx_char;
    logic [$clog2(BUF_DEPTH+1)-1:0] rx_level;
    int n_mismatch = 0;
    int num_checks = 0;
    int n_overrun = 0;
    fsp_row_t rows[6] = '{
        '{8'h55, 8'ha3, 8'h55, '{8'ha3, 1'b0}},
        '{8'h00, 8'hff, 8'h00, '{8'hff, 1'b0}},
        '{8'hff, 8'h00, 8'hff, '{8'h00, 1'b0}},
        '{8'h01, 8'h80, 8'h01, '{8'h80, 1'b0}},
        '{8'h80, 8'h01, 8'h80, '{8'h01, 1'b0}},
        '{8'h3a, 8'hc6, 8'h3a, '{8'hc6, 1'b0}}
    };
    initial begin
        forever #4 clk = ~clk;
    end
    fsp_port #(.DEPTH(DEPTH), .MARGIN(MARGIN)) fsp_port_i (
        .clk(clk), .arst_n(arst_n), .port_open(port_open),
        .gp_pin_zero(host_txd), .gp_pin_one(dev_txd),
        .gp_pin_two_n(rts_n), .gp_pin_three_n(cts_n),
        .rx_pullup_en(rx_pullup_en), .cts_pullup_en(cts_pullup_en),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .tx_busy(tx_busy), .rx_char(rx_char), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .rx_overrun(rx_overrun), .rx_level(rx_level));
    fsp_host_model #(.BIT_CYC(BIT_CYC)) fsp_host_model_i (
        .clk(clk), .host_txd(host_txd), .host_rxd(dev_txd),
        .rts_n(rts_n), .cts_n(cts_n), .cts_hold(cts_hold),
        .ignore_rts(ignore_rts), .bad_stop(bad_stop));
    always @(posedge clk) begin
        if (rx_overrun === 1'b1) n_overrun++;
    end
    // ==========================================================
    // Tasks
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time,
                     seen, exp);
        end
    endtask : check
    task automatic results;
        $display("Checks made %0d, mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : results
    task automatic dev_send(input fsp_byte_t b);
        int n;
        n = 0;
        @(posedge clk);
        tx_data <= b;
        tx_valid <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (tx_ready !== 1'b1 && n < 5000);
        tx_valid <= 1'b0;
    endtask : dev_send
    task automatic dev_get(input fsp_char_t exp);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (rx_valid !== 1'b1 && n < 2000);
        check({rx_valid, rx_char}, {1'b1, exp});
        rx_ready <= 1'b1;
        @(posedge clk);
        rx_ready <= 1'b0;
    endtask : dev_get
    task automatic host_get(input fsp_byte_t exp);
        int n;
        n = 0;
        while (fsp_host_model_i.rx_q.size() == 0 && n < 2000) begin
            @(posedge clk);
            n++;
        end
        if (fsp_host_model_i.rx_q.size() == 0) check(16'h0100, exp);
        else check(fsp_host_model_i.rx_q.pop_front(), exp);
    endtask : host_get
    // ==========================================================
    // Sequence
    initial begin
        repeat (2) @(posedge clk);
        check(dev_txd, LINE_IDLE);
        check(rts_n, HS_OFF);
        check({rx_pullup_en, cts_pullup_en}, {2{PULLUP_ON}});
        @(posedge clk) arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        check(rts_n, HS_OFF);
        check(tx_ready, 1'b0);
        port_open <= 1'b1;
        repeat (2) @(posedge clk);
        check(rts_n, HS_ON);
        check(dev_txd, LINE_IDLE);
        $display("Test reset and idle levels done");
        // Both directions run at once on every row.
        foreach (rows[i]) begin
            fork
                dev_send(rows[i].tx_in);
                fsp_host_model_i.send_byte(rows[i].rx_in);
            join
            fork
                host_get(rows[i].host_exp);
                dev_get(rows[i].char_exp);
            join
        end
        check(fsp_host_model_i.stop_errs, 0);
        $display("Test full duplex rows done");
        cts_hold <= 1'b1;
        repeat (4) @(posedge clk);
        fork
            dev_send(8'h3c);
            begin
                repeat (300) @(posedge clk);
                check(tx_busy, 1'b0);
                check(dev_txd, LINE_IDLE);
                cts_hold <= 1'b0;
            end
        join
        host_get(8'h3c);
        $display("Test clear-to-send hold done");
        dev_send(8'hc5);
        repeat (2) @(posedge clk);
        check(tx_busy, 1'b1);
        check(dev_txd, START_LEVEL);
        dev_send(8'h5c);
        host_get(8'hc5);
        host_get(8'h5c);
        $display("Test back to back transmit done");
        bad_stop <= 1'b1;
        fsp_host_model_i.send_byte(8'h96);
        bad_stop <= 1'b0;
        dev_get('{8'h96, 1'b1});
        repeat (4 * BIT_CYC) @(posedge clk);
        check(rx_valid, 1'b0);
        $display("Test bad stop bit done");
        // The host ignores the request line here so the buffer overflows.
        ignore_rts <= 1'b1;
        for (int i = 0; i < DEPTH + 2; i++) begin
            fsp_host_model_i.send_byte(8'(i));
            if (i == DEPTH - MARGIN - 1) check(rts_n, HS_ON);
            if (i == DEPTH - MARGIN) check(rts_n, HS_OFF);
        end
        check(rx_level, DEPTH);
        check(n_overrun, 1);
        ignore_rts <= 1'b0;
        for (int i = 0; i <= DEPTH; i++) dev_get('{8'(i), 1'b0});
        repeat (4) @(posedge clk);
        check(rx_level, 0);
        check(rts_n, HS_ON);
        $display("Test buffer fill and drain done");
        // A reset in mid-run with the port open must restore idle levels.
        @(posedge clk) arst_n <= 1'b0;
        @(posedge clk);
        check(dev_txd, LINE_IDLE);
        check(rts_n, HS_OFF);
        check({rx_valid, rx_level}, '0);
        @(posedge clk) arst_n <= 1'b1;
        repeat (2) @(posedge clk);
        check(rts_n, HS_ON);
        check(tx_busy, 1'b0);
        $display("Test mid-run reset done");
        results();
    end
    initial begin
        repeat (80000) @(posedge clk);
        n_mismatch++;
        $display("Watchdog expired before the tests ended");
        results();
    end
endmodule : test_fsp_port
